/* File: design/lgc_regs.sv */
// Global control register bank of a single channel T1/E1/J1 line interface.
// Assumes one AHB-Lite master, hclk at 200 MHz, line logic feeding events and status.
// Contract
// - Any write to the soft reset register returns every register to its default, except the line standard select bit.
// - The soft reset leaves the line standard select bit as last written.
// - After any reset every line driver output is put in high impedance.
// - The soft reset register stores nothing; a write only triggers the reset.
// - The revision register is read-only and returns the 8-bit identification code.
// - Global configuration bit 2 selects E1 when 0 and T1/J1 when 1.
// - The interrupt pin field gives open-drain low for x0, push-pull low for 01, push-pull high for 11.
// - Transmit termination bits 5-3 pick 75, 120, 100 or 110 ohms, or external for 1xx.
// - Receive termination bits 2-0 pick 75, 120, 100 or 110 ohms, or external for 1xx.
// - Jitter configuration bit 5 selects limit mode when set, resets to 1.
// - Jitter placement 00 or 10 disables, 01 puts it in transmit, 11 in receive.
// - Jitter depth 00 gives 128 bits, 01 gives 64 bits, 1x gives 32 bits.
// - Jitter bandwidth bit selects the low corner when 0 and the high one when 1.
//
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module lgc_regs
  import lgc_pkg::*;
#(
  parameter logic [7:0] SILICON_REVISION_CODE = 8'h5a, // Arbitrary value.
  parameter int         SETTLE_COUNT          = SETTLE_CYCLES
) (
  // Clock and reset
  input  wire  logic        hclk,
  input  wire  logic        hresetn,
  // AHB-Lite slave
  input  wire  logic        hsel,
  input  wire  logic [31:0] haddr,
  input  wire  logic [1:0]  htrans,
  input  wire  logic        hwrite,
  input  wire  logic [2:0]  hsize,
  input  wire  logic [31:0] hwdata,
  input  wire  logic        hready,
  output var   logic [31:0] hrdata,
  output var   logic        hreadyout,
  output var   logic        hresp,
  // Line side status and events
  input  wire  logic [7:0]  line_status_0,
  input  wire  logic [7:0]  line_status_1,
  input  wire  logic [15:0] irq_event,
  input  wire  logic [15:0] error_count,
  // Decoded configuration and driver control
  output var   lgc_cfg_s    cfg,
  output var   logic        line_driver_hiz,
  output var   logic        soft_reset_pulse,
  output var   logic        settle_busy,
  // Interrupt pin, two signals
  output var   logic        irq_o,
  output var   logic        irq_oe
);

  // ----------------------------------------------------------------------
  // Field decoders
  // ----------------------------------------------------------------------
  // Only the low two bits choose an internal value; the top bit of the field
  // travels on its own as the external resistor flag, so it is not read here.
  function automatic lgc_imp_e imp_dec(input logic [2:0] f);
    return lgc_imp_e'(f[1:0]);
  endfunction

  // Depth goes out as the bit count itself, so the line logic needs no decode.
  function automatic logic [7:0] depth_dec(input logic [1:0] f);
    if (f[1]) begin
      return 8'h20;
    end else if (f[0]) begin
      return 8'h40;
    end
    return 8'h80;
  endfunction

  // Bit 3 alone enables the attenuator; bit 4 then only picks the path.
  function automatic lgc_ja_place_e place_dec(input logic [1:0] f);
    if (!f[0]) begin
      return LGC_JA_OFF;
    end
    return f[1] ? LGC_JA_RX : LGC_JA_TX;
  endfunction

  // ----------------------------------------------------------------------
  // Decoded view of the register defaults
  // ----------------------------------------------------------------------
  // The decoded outputs show the register defaults while hard reset is held,
  // so the line logic never sees limit mode off or a zero depth before the
  // first clock edge.
  localparam lgc_cfg_s CFG_RST = '{
    line_standard_select:    RST_GLOBAL_CFG[POS_LINE_STD],
    tx_external:             RST_TERM[5],
    tx_impedance:            imp_dec(RST_TERM[5:3]),
    rx_external:             RST_TERM[2],
    rx_impedance:            imp_dec(RST_TERM[2:0]),
    jitter_limit_mode:       RST_JITTER_ATTEN_CONFIG[POS_JIT_LIMIT],
    jitter_atten_placement:  place_dec(RST_JITTER_ATTEN_CONFIG[4:3]),
    jitter_atten_depth:      depth_dec(RST_JITTER_ATTEN_CONFIG[2:1]),
    jitter_bandwidth_select: RST_JITTER_ATTEN_CONFIG[0]
  };

  // ----------------------------------------------------------------------
  // Bus phase capture
  // ----------------------------------------------------------------------
  lgc_phase_e  phase_r, phase_nxt;
  logic [7:0]  idx_r, idx_nxt;
  logic        addr_ok;

  // Misaligned addresses and those above 0x3ff are dropped here, so they neither write
  // nor clear status; the bus still answers OKAY. hsize is not decoded: every
  // register sits in the low byte of its word, so any access size that reaches
  // that byte behaves the same.
  always_comb begin
    addr_ok   = (haddr[1:0] == 2'b00) && (haddr[31:10] == 22'h0);
    phase_nxt = LGC_ST_IDLE;
    idx_nxt   = idx_r;
    if (hsel && hready && htrans[1] && addr_ok) begin
      phase_nxt = hwrite ? LGC_ST_WRITE : LGC_ST_READ;
      idx_nxt   = haddr[9:2];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_r <= LGC_ST_IDLE;
      idx_r   <= 8'h00;
    end else begin
      phase_r <= phase_nxt;
      idx_r   <= idx_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------
  logic [7:0] gcf_r, gcf_nxt;
  logic [7:0] term_r, term_nxt;
  logic [7:0] jitter_atten_config_r, jitter_atten_config_nxt;
  logic [7:0] lcl_r, lcl_nxt;
  logic [7:0] tx_code_r, tx_code_nxt;
  logic [7:0] act_code_r, act_code_nxt;
  logic [7:0] deact_code_r, deact_code_nxt;
  logic [7:0] errc_r, errc_nxt;
  logic [7:0] mask0_r, mask0_nxt;
  logic [7:0] mask1_r, mask1_nxt;
  logic [7:0] edge_r, edge_nxt;
  // Both status bytes live in one word so that the mask and the interrupt
  // level are formed in a single step.
  logic [15:0] ists_r, ists_nxt;
  logic [7:0] wd;
  logic       wr;
  logic       rd;
  logic       srst;

  always_comb begin
    wd   = hwdata[7:0];
    wr   = (phase_r == LGC_ST_WRITE);
    rd   = (phase_r == LGC_ST_READ);
    srst = wr && (idx_r == IDX_SOFT_RESET);
    gcf_nxt        = gcf_r;
    term_nxt       = term_r;
    jitter_atten_config_nxt       = jitter_atten_config_r;
    lcl_nxt        = lcl_r;
    tx_code_nxt    = tx_code_r;
    act_code_nxt   = act_code_r;
    deact_code_nxt = deact_code_r;
    errc_nxt       = errc_r;
    mask0_nxt      = mask0_r;
    mask1_nxt      = mask1_r;
    edge_nxt       = edge_r;
    ists_nxt       = ists_r;
    if (rd && (idx_r == IDX_IRQ_STATUS_0)) begin
      ists_nxt[7:0] = 8'h00;
    end
    if (rd && (idx_r == IDX_IRQ_STATUS_1)) begin
      ists_nxt[15:8] = 8'h00;
    end
    // Set after clear so an event in the read cycle is kept.
    ists_nxt = ists_nxt | irq_event;
    if (wr) begin
      case (idx_r)
        IDX_GLOBAL_CONFIG:    gcf_nxt        = wd & GCF_WMASK;
        IDX_LINE_IMPEDANCE:   term_nxt       = wd & TERM_WMASK;
        IDX_JITTER_ATTEN:     jitter_atten_config_nxt       = wd & JITTER_ATTEN_CONFIG_WMASK;
        IDX_LOOP_CODE_LENGTH: lcl_nxt        = wd & LCL_WMASK;
        IDX_TX_LOOP_CODE:     tx_code_nxt    = wd;
        IDX_RX_LOOP_ACT:      act_code_nxt   = wd;
        IDX_RX_LOOP_DEACT:    deact_code_nxt = wd;
        IDX_ERR_INS_CNT_CTRL: errc_nxt       = wd & ERRC_WMASK;
        IDX_IRQ_MASK_0:       mask0_nxt      = wd;
        IDX_IRQ_MASK_1:       mask1_nxt      = wd;
        IDX_IRQ_EDGE_SELECT:  edge_nxt       = wd;
        // Read-only and write-only indices land here and store nothing.
        default: begin
        end
      endcase
    end
    // The bus phase registers are left alone so the transfer in flight ends
    // normally; an event in this cycle is kept, as on a status read.
    if (srst) begin
      gcf_nxt        = (RST_GLOBAL_CFG & ~(8'h01 << POS_LINE_STD)) | (gcf_r & (8'h01 << POS_LINE_STD));
      term_nxt       = RST_TERM;
      jitter_atten_config_nxt       = RST_JITTER_ATTEN_CONFIG;
      lcl_nxt        = RST_ZERO;
      tx_code_nxt    = RST_ZERO;
      act_code_nxt   = RST_ZERO;
      deact_code_nxt = RST_ZERO;
      errc_nxt       = RST_ZERO;
      mask0_nxt      = RST_ZERO;
      mask1_nxt      = RST_ZERO;
      edge_nxt       = RST_ZERO;
      ists_nxt       = irq_event;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gcf_r        <= RST_GLOBAL_CFG;
      term_r       <= RST_TERM;
      jitter_atten_config_r       <= RST_JITTER_ATTEN_CONFIG;
      lcl_r        <= RST_ZERO;
      tx_code_r    <= RST_ZERO;
      act_code_r   <= RST_ZERO;
      deact_code_r <= RST_ZERO;
      errc_r       <= RST_ZERO;
      mask0_r      <= RST_ZERO;
      mask1_r      <= RST_ZERO;
      edge_r       <= RST_ZERO;
      ists_r       <= 16'h0000;
    end else begin
      gcf_r        <= gcf_nxt;
      term_r       <= term_nxt;
      jitter_atten_config_r       <= jitter_atten_config_nxt;
      lcl_r        <= lcl_nxt;
      tx_code_r    <= tx_code_nxt;
      act_code_r   <= act_code_nxt;
      deact_code_r <= deact_code_nxt;
      errc_r       <= errc_nxt;
      mask0_r      <= mask0_nxt;
      mask1_r      <= mask1_nxt;
      edge_r       <= edge_nxt;
      ists_r       <= ists_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  logic [31:0] hrdata_nxt;
  logic [7:0]  rsel;

  always_comb begin
    case (idx_nxt)
      IDX_SILICON_REVISION: rsel = SILICON_REVISION_CODE;
      IDX_GLOBAL_CONFIG:    rsel = gcf_nxt;
      IDX_LINE_IMPEDANCE:   rsel = term_nxt;
      IDX_JITTER_ATTEN:     rsel = jitter_atten_config_nxt;
      IDX_LOOP_CODE_LENGTH: rsel = lcl_nxt;
      IDX_TX_LOOP_CODE:     rsel = tx_code_nxt;
      IDX_RX_LOOP_ACT:      rsel = act_code_nxt;
      IDX_RX_LOOP_DEACT:    rsel = deact_code_nxt;
      IDX_ERR_INS_CNT_CTRL: rsel = errc_nxt;
      IDX_IRQ_MASK_0:       rsel = mask0_nxt;
      IDX_IRQ_MASK_1:       rsel = mask1_nxt;
      IDX_IRQ_EDGE_SELECT:  rsel = edge_nxt;
      IDX_LINE_STATUS_0:    rsel = line_status_0;
      IDX_LINE_STATUS_1:    rsel = line_status_1 & LINE_STATUS_1_MASK;
      IDX_IRQ_STATUS_0:     rsel = ists_nxt[7:0];
      IDX_IRQ_STATUS_1:     rsel = ists_nxt[15:8];
      IDX_ERROR_COUNT_LOW:  rsel = error_count[7:0];
      IDX_ERROR_COUNT_HIGH: rsel = error_count[15:8];
      default:              rsel = 8'h00;
    endcase
    hrdata_nxt = HRDATA_ZERO;
    if (phase_nxt == LGC_ST_READ) begin
      hrdata_nxt = {24'h000000, rsel};
    end
  end

  // Read data is sampled a cycle early from the next-state values at the end of the address
  // phase; the clear-on-read of status lands one edge later, at the end of the data phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= HRDATA_ZERO;
    end else begin
      hrdata <= hrdata_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Settling timer after a line standard change
  // ----------------------------------------------------------------------
  // A 32-bit count lets SETTLE_COUNT grow for a faster clock with no change
  // here, at the cost of a few spare flops. The timer does not lock the bus:
  // keeping to the wait is the host's job, settle_busy only shows the wait.
  logic [31:0] settle_cnt_r, settle_cnt_nxt;

  always_comb begin
    settle_cnt_nxt = settle_cnt_r;
    // Only a real change of the standard bit starts the wait.
    if (gcf_nxt[POS_LINE_STD] != gcf_r[POS_LINE_STD]) begin
      settle_cnt_nxt = 32'(SETTLE_COUNT);
    end else if (settle_cnt_r != 32'h0) begin
      settle_cnt_nxt = settle_cnt_r - 32'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      settle_cnt_r <= 32'h0;
    end else begin
      settle_cnt_r <= settle_cnt_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Decoded outputs and interrupt pin
  // ----------------------------------------------------------------------
  // hreadyout and hresp are registered constants: the bank answers every
  // transfer at once and never signals an error.
  lgc_cfg_s cfg_nxt;
  logic     irq_act;
  logic     irq_o_nxt;
  logic     irq_oe_nxt;

  always_comb begin
    cfg_nxt.line_standard_select    = gcf_nxt[POS_LINE_STD];
    cfg_nxt.tx_external             = term_nxt[5];
    cfg_nxt.tx_impedance            = imp_dec(term_nxt[5:3]);
    cfg_nxt.rx_external             = term_nxt[2];
    cfg_nxt.rx_impedance            = imp_dec(term_nxt[2:0]);
    cfg_nxt.jitter_limit_mode       = jitter_atten_config_nxt[POS_JIT_LIMIT];
    cfg_nxt.jitter_atten_placement  = place_dec(jitter_atten_config_nxt[4:3]);
    cfg_nxt.jitter_atten_depth      = depth_dec(jitter_atten_config_nxt[2:1]);
    cfg_nxt.jitter_bandwidth_select = jitter_atten_config_nxt[0];
    // In open-drain mode the pin is only ever pulled low and the pull-up gives
    // the idle level, so the value stays 0 and the enable carries the request.
    irq_act    = |(ists_nxt & ~{mask1_nxt, mask0_nxt});
    irq_o_nxt  = 1'b0;
    irq_oe_nxt = 1'b0;
    if (!gcf_nxt[0]) begin
      irq_oe_nxt = irq_act;
    end else begin
      irq_oe_nxt = 1'b1;
      irq_o_nxt  = gcf_nxt[1] ? irq_act : !irq_act;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg              <= CFG_RST;
      line_driver_hiz  <= 1'b1;
      soft_reset_pulse <= 1'b0;
      settle_busy      <= 1'b0;
      irq_o            <= 1'b0;
      irq_oe           <= 1'b0;
      hreadyout        <= 1'b1;
      hresp            <= 1'b0;
    end else begin
      cfg              <= cfg_nxt;
      line_driver_hiz  <= srst;
      soft_reset_pulse <= srst;
      settle_busy      <= (settle_cnt_nxt != 32'h0);
      irq_o            <= irq_o_nxt;
      irq_oe           <= irq_oe_nxt;
      hreadyout        <= 1'b1;
      hresp            <= 1'b0;
    end
  end

endmodule // lgc_regs

`default_nettype wire

/* File: design/lgc_pkg.sv */
// Package for the line interface global control register bank.
// Assumes an AHB-Lite slave with 32-bit data, one register per aligned word.
package lgc_pkg;

  // ----------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [7:0] IDX_SILICON_REVISION   = 8'h00;
  localparam logic [7:0] IDX_SOFT_RESET         = 8'h01;
  localparam logic [7:0] IDX_GLOBAL_CONFIG      = 8'h02;
  localparam logic [7:0] IDX_LINE_IMPEDANCE     = 8'h03;
  localparam logic [7:0] IDX_JITTER_ATTEN       = 8'h04;
  localparam logic [7:0] IDX_LOOP_CODE_LENGTH   = 8'h0f;
  localparam logic [7:0] IDX_TX_LOOP_CODE       = 8'h10;
  localparam logic [7:0] IDX_RX_LOOP_ACT        = 8'h11;
  localparam logic [7:0] IDX_RX_LOOP_DEACT      = 8'h12;
  localparam logic [7:0] IDX_ERR_INS_CNT_CTRL   = 8'h13;
  localparam logic [7:0] IDX_IRQ_MASK_0         = 8'h14;
  localparam logic [7:0] IDX_IRQ_MASK_1         = 8'h15;
  localparam logic [7:0] IDX_IRQ_EDGE_SELECT    = 8'h16;
  localparam logic [7:0] IDX_LINE_STATUS_0      = 8'h17;
  localparam logic [7:0] IDX_LINE_STATUS_1      = 8'h18;
  localparam logic [7:0] IDX_IRQ_STATUS_0       = 8'h19;
  localparam logic [7:0] IDX_IRQ_STATUS_1       = 8'h1a;
  localparam logic [7:0] IDX_ERROR_COUNT_LOW    = 8'h1b;
  localparam logic [7:0] IDX_ERROR_COUNT_HIGH   = 8'h1c;

  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int         POS_LINE_STD     = 2;
  localparam int         POS_JIT_LIMIT    = 5;
  localparam logic [7:0] GCF_WMASK        = 8'h07;
  localparam logic [7:0] TERM_WMASK       = 8'h3f;
  localparam logic [7:0] JITTER_ATTEN_CONFIG_WMASK       = 8'h3f;
  localparam logic [7:0] LCL_WMASK        = 8'h3f;
  localparam logic [7:0] ERRC_WMASK       = 8'h7f;
  localparam logic [7:0] LINE_STATUS_1_MASK       = 8'h3f;
  localparam logic [7:0] RST_GLOBAL_CFG   = 8'h00;
  localparam logic [7:0] RST_TERM         = 8'h00;
  localparam logic [7:0] RST_JITTER_ATTEN_CONFIG         = 8'h20;
  localparam logic [7:0] RST_ZERO         = 8'h00;
  localparam logic [31:0] HRDATA_ZERO     = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // Settling time after a line standard change
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_PS   = 5000;
  localparam int SETTLE_TIME_US  = 50;
  localparam int SETTLE_CYCLES   = (SETTLE_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ----------------------------------------------------------------------
  // Decoded configuration carried to the line logic
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    LGC_JA_OFF = 2'b00,
    LGC_JA_TX  = 2'b01,
    LGC_JA_RX  = 2'b10
  } lgc_ja_place_e;

  typedef enum logic [1:0] {
    LGC_IMP_75  = 2'b00,
    LGC_IMP_120 = 2'b01,
    LGC_IMP_100 = 2'b10,
    LGC_IMP_110 = 2'b11
  } lgc_imp_e;

  typedef struct packed {
    logic          line_standard_select;
    logic          tx_external;
    lgc_imp_e      tx_impedance;
    logic          rx_external;
    lgc_imp_e      rx_impedance;
    logic          jitter_limit_mode;
    lgc_ja_place_e jitter_atten_placement;
    logic [7:0]    jitter_atten_depth;
    logic          jitter_bandwidth_select;
  } lgc_cfg_s;

  typedef enum logic [1:0] {
    LGC_ST_IDLE  = 2'b00,
    LGC_ST_WRITE = 2'b01,
    LGC_ST_READ  = 2'b10
  } lgc_phase_e;

endpackage : lgc_pkg

/* File: tb/lgc_regs_assertions.sv */
// Checker for the global control register bank, bound to every lgc_regs.
// Assumes a single AHB-Lite master and one clock domain.
`timescale 1ns/1ps
`default_nettype none
module lgc_regs_chk
  import lgc_pkg::*;
#(
  parameter logic [7:0] REV = 8'h5a // Arbitrary value.
) (
  // Clock, reset and bus
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Outputs under watch
  input wire lgc_cfg_s    cfg,
  input wire logic        line_driver_hiz,
  input wire logic        soft_reset_pulse,
  input wire logic        settle_busy,
  input wire logic        irq_o,
  input wire logic        irq_oe
);
  // --------------------------------------------------------------------
  // Data phase tracking
  // --------------------------------------------------------------------
  logic        rd_r;
  logic        wr_r;
  logic [31:0] a_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_r <= 1'h0;
      wr_r <= 1'h0;
      a_r  <= 32'h0;
    end else begin
      rd_r <= hsel && hready && htrans[1] && !hwrite;
      wr_r <= hsel && hready && htrans[1] && hwrite;
      a_r  <= haddr;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // --------------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------------
  property p_bus_ok; hreadyout && !hresp; endproperty
  property p_srst; wr_r && a_r == 32'h4 |-> ##[1:2] soft_reset_pulse; endproperty
  property p_hiz; soft_reset_pulse |-> ##[0:1] line_driver_hiz; endproperty
  property p_std_kept; soft_reset_pulse |-> $stable(cfg.line_standard_select) [*2]; endproperty
  property p_rev; rd_r && a_r == 32'h0 |-> hrdata == {24'h0, REV}; endproperty
  property p_rst_empty; rd_r && a_r == 32'h4 |-> hrdata == 32'h0; endproperty
  property p_gcf_resv; rd_r && a_r == 32'h8 |-> hrdata[31:3] == 29'h0; endproperty
  property p_place;
    wr_r && a_r == 32'h10 |=> cfg.jitter_atten_placement ==
      ($past(hwdata[4:3]) == 2'b01 ? 2'h1 : ($past(hwdata[4:3]) == 2'b11 ? 2'h2 : 2'h0));
  endproperty
  property p_depth; $past(hresetn) |-> cfg.jitter_atten_depth inside {8'h80, 8'h40, 8'h20}; endproperty
  property p_pin; !irq_oe |-> !irq_o; endproperty
  a_bus_ok: assert property (p_bus_ok) else $error("bus answer not ready or not okay");
  a_srst: assert property (p_srst) else $error("soft reset write gave no pulse");
  a_hiz: assert property (p_hiz) else $error("drivers not high impedance after soft reset");
  a_std_kept: assert property (p_std_kept) else $error("line standard lost on soft reset");
  a_rev: assert property (p_rev) else $error("revision read wrong");
  a_rst_empty: assert property (p_rst_empty) else $error("soft reset register holds data");
  a_gcf_resv: assert property (p_gcf_resv) else $error("reserved config bits not zero");
  a_place: assert property (p_place) else $error("placement does not follow the written field");
  a_depth: assert property (p_depth) else $error("illegal depth decode");
  a_pin: assert property (p_pin) else $error("pin driven while disabled");
  c_srst: cover property (soft_reset_pulse);
  c_settle: cover property (settle_busy);
  c_irq: cover property (irq_oe && irq_o);
endmodule // lgc_regs_chk
bind lgc_regs lgc_regs_chk #(.REV(SILICON_REVISION_CODE)) u_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .cfg(cfg), .line_driver_hiz(line_driver_hiz),
  .soft_reset_pulse(soft_reset_pulse), .settle_busy(settle_busy),
  .irq_o(irq_o), .irq_oe(irq_oe));
`default_nettype wire

/* File: tb/lgc_line_model.sv */
// Line side model: settable status and counter values, one-cycle event pulses.
// Assumes the bench calls pulse just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module lgc_line_model (
  // Clock
  input wire logic         hclk,
  // Status and events
  output var logic [7:0]  line_status_0,
  output var logic [7:0]  line_status_1,
  output var logic [15:0] error_count,
  output var logic [15:0] irq_event
);
  initial begin
    line_status_0 = 8'ha5;
    line_status_1 = 8'hff;
    error_count   = 16'h1234;
    irq_event     = 16'h0;
  end
  task automatic set_line(input logic [7:0] s0, input logic [7:0] s1, input logic [15:0] c);
    line_status_0 <= s0;
    line_status_1 <= s1;
    error_count   <= c;
  endtask
  task automatic pulse(input int b);
    @(posedge hclk);
    irq_event <= 16'h1 << b;
    @(posedge hclk);
    irq_event <= 16'h0;
  endtask
endmodule // lgc_line_model
`default_nettype wire

/* File: tb/lineif_global_control_regs_tb.sv */
// Bench for the global control register bank over AHB-Lite.
// Assumes the bound checker and the line side model beside the bank.
`timescale 1ns/1ps
`default_nettype none
module lineif_global_control_regs_tb;
  import lgc_pkg::*;
  logic hclk = 1'h0;
  logic hresetn, hsel, hwrite, hreadyout, hresp, hiz, srp, busy, irq_o, irq_oe;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  st0, st1;
  logic [15:0] ev, cnt;
  lgc_cfg_s    cfg;
  int fails = 0, tests_run = 0, cyc = 0, i, k;
  logic [1:0] pl [4] = '{2'h0, 2'h1, 2'h0, 2'h2};
  logic [7:0] dp [4] = '{8'h80, 8'h40, 8'h20, 8'h20};
  logic [7:0] ix [8] = '{8'h0f, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16};
  logic [7:0] wm [8] = '{8'h3f, 8'hff, 8'hff, 8'hff, 8'h7f, 8'hff, 8'hff, 8'hff};
  always #2.5 hclk = ~hclk;
  lgc_regs #(.SILICON_REVISION_CODE(8'hc3), .SETTLE_COUNT(20)) i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .line_status_0(st0), .line_status_1(st1),
    .irq_event(ev), .error_count(cnt), .cfg(cfg), .line_driver_hiz(hiz),
    .soft_reset_pulse(srp), .settle_busy(busy), .irq_o(irq_o), .irq_oe(irq_oe));
  lgc_line_model i_line (.hclk(hclk), .line_status_0(st0), .line_status_1(st1),
    .error_count(cnt), .irq_event(ev));
  // ----------------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic xfer(input logic w, input logic [31:0] a, input logic [7:0] d);
    hsel <= 1'h1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'h1);
    q = hrdata;
  endtask
  task automatic rd(input logic [31:0] a, input logic [7:0] e);
    xfer(1'h0, a, 8'h0);
    chk($sformatf("reg %h", a), {24'h0, e}, q);
  endtask
  task automatic pin(input logic eo, input logic eoe);
    for (i = 0; i < 8 && (irq_o !== eo || irq_oe !== eoe); i++) @(posedge hclk);
    chk("irq_o", eo, irq_o);
    chk("irq_oe", eoe, irq_oe);
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      complete_run;
    end
  end
  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  initial begin
    {hsel, hwrite, htrans, hsize, haddr, hwdata, hresetn} = '0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    rd(32'h0, 8'hc3);
    xfer(1'h1, 32'h0, 8'hff);
    rd(32'h0, 8'hc3);
    rd(32'h4, 8'h00);
    rd(32'h8, 8'h00);
    rd(32'h10, 8'h20);
    rd(32'h3fc, 8'h00);
    chk("limit", 1, cfg.jitter_limit_mode);
    xfer(1'h1, 32'hc, 8'hff);
    rd(32'hc, 8'h3f);
    chk("tx_ext", 1, cfg.tx_external);
    chk("rx_ext", 1, cfg.rx_external);
    for (k = 0; k < 4; k++) begin
      xfer(1'h1, 32'hc, {2'h0, 1'h0, k[1:0], 1'h0, k[1:0]});
      @(posedge hclk);
      chk("tx_imp", k[1:0], cfg.tx_impedance);
      chk("rx_imp", k[1:0], cfg.rx_impedance);
      xfer(1'h1, 32'h10, {3'h0, k[1:0], k[1:0], k[0]});
      @(posedge hclk);
      chk("place", pl[k], cfg.jitter_atten_placement);
      chk("depth", dp[k], cfg.jitter_atten_depth);
      chk("bw", k[0], cfg.jitter_bandwidth_select);
      chk("limit", 0, cfg.jitter_limit_mode);
    end
    xfer(1'h1, 32'h10, 8'hff);
    rd(32'h10, 8'h3f);
    xfer(1'h1, 32'h8, 8'hff);
    for (i = 0; i < 4 && busy !== 1'h1; i++) @(posedge hclk);
    chk("busy", 1, busy);
    for (i = 0; i < 40 && busy !== 1'h0; i++) @(posedge hclk);
    chk("busy", 0, busy);
    chk("std", 1, cfg.line_standard_select);
    rd(32'h8, 8'h07);
    for (k = 0; k < 8; k++) begin
      xfer(1'h1, {22'h0, ix[k], 2'h0}, 8'hff);
      rd({22'h0, ix[k], 2'h0}, wm[k]);
    end
    xfer(1'h1, 32'h4, 8'h5a);
    for (i = 0; i < 4 && hiz !== 1'h1; i++) @(posedge hclk);
    chk("hiz", 1, hiz);
    rd(32'h8, 8'h04);
    rd(32'hc, 8'h00);
    rd(32'h10, 8'h20);
    for (k = 0; k < 8; k++) rd({22'h0, ix[k], 2'h0}, 8'h00);
    xfer(1'h1, 32'h8, 8'h05);
    xfer(1'h1, 32'h50, 8'h00);
    i_line.pulse(3);
    pin(1'h0, 1'h1);
    rd(32'h64, 8'h08);
    pin(1'h1, 1'h1);
    xfer(1'h1, 32'h50, 8'h08);
    i_line.pulse(3);
    repeat (4) @(posedge hclk);
    chk("masked", 1, irq_o);
    xfer(1'h0, 32'h64, 8'h0);
    xfer(1'h1, 32'h50, 8'h00);
    xfer(1'h1, 32'h8, 8'h07);
    i_line.pulse(3);
    pin(1'h1, 1'h1);
    xfer(1'h0, 32'h64, 8'h0);
    xfer(1'h1, 32'h8, 8'h06);
    i_line.pulse(3);
    pin(1'h0, 1'h1);
    rd(32'h64, 8'h08);
    pin(1'h0, 1'h0);
    i_line.pulse(11);
    pin(1'h0, 1'h1);
    rd(32'h68, 8'h08);
    pin(1'h0, 1'h0);
    rd(32'h5c, 8'ha5);
    rd(32'h60, 8'h3f);
    rd(32'h6c, 8'h34);
    rd(32'h70, 8'h12);
    i_line.set_line(8'h3c, 8'hc3, 16'h9876);
    rd(32'h5c, 8'h3c);
    rd(32'h60, 8'h03);
    rd(32'h6c, 8'h76);
    rd(32'h70, 8'h98);
    complete_run;
  end
endmodule // lineif_global_control_regs_tb
`default_nettype wire
